// >>> rtl/mfc_pkg.sv
// Shared constants, register map and field layouts of the card register bank
package mfc_pkg;

  // Bus geometry
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_OCR      = 8'h00;
  localparam logic [7:0] OFS_CID_W0   = 8'h10;
  localparam logic [7:0] OFS_CID_W1   = 8'h14;
  localparam logic [7:0] OFS_CID_W2   = 8'h18;
  localparam logic [7:0] OFS_CID_W3   = 8'h1C;
  localparam logic [7:0] OFS_CSD_W0   = 8'h20;
  localparam logic [7:0] OFS_CSD_W1   = 8'h24;
  localparam logic [7:0] OFS_CSD_W2   = 8'h28;
  localparam logic [7:0] OFS_CSD_W3   = 8'h2C;
  localparam logic [7:0] OFS_CONTROL  = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h34;
  localparam logic [7:0] OFS_SERIAL   = 8'h38;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Control and status bits
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned STAT_READY_BIT   = 0;
  localparam int unsigned STAT_CRC_OK_BIT  = 1;
  localparam int unsigned STAT_STATE_LSB   = 4;

  // Operating-conditions layout, busy bit cleared
  localparam int unsigned OCR_BUSY_BIT     = 31;
  localparam logic [1:0]  OCR_ACCESS_MODE  = 2'h2;
  localparam logic [4:0]  OCR_RSVD_HI      = 5'h00;
  localparam logic [8:0]  OCR_WIN_HIGH     = 9'h1FF;
  localparam logic [6:0]  OCR_WIN_MID      = 7'h00;
  localparam logic        OCR_WIN_LOW      = 1'b1;
  localparam logic [6:0]  OCR_RSVD_LO      = 7'h00;
  localparam logic [31:0] OCR_FIXED        = {1'b0, OCR_ACCESS_MODE, OCR_RSVD_HI,
                                              OCR_WIN_HIGH, OCR_WIN_MID, OCR_WIN_LOW,
                                              OCR_RSVD_LO};

  // Identity layout
  localparam int unsigned CID_BODY_W   = 120;
  localparam logic [6:0]  CRC7_POLY    = 7'h09;
  localparam logic [5:0]  CID_RSVD     = 6'h00;
  localparam logic        CID_STOP_BIT = 1'b1;

  // Card-specific data fields, most significant first
  localparam logic [1:0]  CSD_STRUCT        = 2'h3;
  localparam logic [3:0]  CSD_SPEC_VERSION  = 4'h4;
  localparam logic [1:0]  CSD_RSVD_121      = 2'h0;
  localparam logic [7:0]  CSD_READ_ACCESS   = 8'h4F;
  localparam logic [7:0]  CSD_ACCESS_CLKS   = 8'h01;
  localparam logic [7:0]  CSD_BUS_SPEED     = 8'h32;
  localparam logic [11:0] CSD_CMD_CLASSES   = 12'h0F5;
  localparam logic [3:0]  CSD_READ_BLOCK    = 4'h9;
  localparam logic [2:0]  CSD_PARTIAL_MIS   = 3'h0;
  localparam logic [2:0]  CSD_DRIVER_RSVD   = 3'h0;
  localparam logic [11:0] CSD_CAPACITY      = 12'hFFF;
  localparam logic [2:0]  CSD_CURRENT       = 3'h7;
  localparam logic [2:0]  CSD_CAPACITY_MULT = 3'h7;
  localparam logic [4:0]  CSD_ERASE_SIZE    = 5'h1F;
  localparam logic [4:0]  CSD_ERASE_MULT    = 5'h1F;
  localparam logic [4:0]  CSD_PROTECT_SIZE  = 5'h0F;
  localparam logic        CSD_PROTECT_EN    = 1'b1;
  localparam logic [1:0]  CSD_DEFAULT_ECC   = 2'h0;
  localparam logic [2:0]  CSD_WRITE_FACTOR  = 3'h2;
  localparam logic [3:0]  CSD_WRITE_BLOCK   = 4'h9;
  localparam logic        CSD_PARTIAL_WR    = 1'b0;
  localparam logic [12:0] CSD_FLAGS_LOW     = 13'h0000;
  localparam logic [6:0]  CSD_CHECKSUM      = 7'h30;
  localparam logic [127:0] CSD_VALUE = {CSD_STRUCT, CSD_SPEC_VERSION, CSD_RSVD_121,
    CSD_READ_ACCESS, CSD_ACCESS_CLKS, CSD_BUS_SPEED, CSD_CMD_CLASSES, CSD_READ_BLOCK,
    CSD_PARTIAL_MIS, CSD_DRIVER_RSVD, CSD_CAPACITY, CSD_CURRENT, CSD_CURRENT,
    CSD_CURRENT, CSD_CURRENT, CSD_CAPACITY_MULT, CSD_ERASE_SIZE, CSD_ERASE_MULT,
    CSD_PROTECT_SIZE, CSD_PROTECT_EN, CSD_DEFAULT_ECC, CSD_WRITE_FACTOR,
    CSD_WRITE_BLOCK, CSD_PARTIAL_WR, CSD_FLAGS_LOW, CSD_CHECKSUM, 1'b1};

  // Power-up timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned POWERUP_TIME_NS = 1000000;
  localparam int unsigned POWERUP_CYCLES  = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;

  // Power-up sequencer states
  typedef enum logic [3:0] {
    PWR_RESET = 4'b0001,
    PWR_COUNT = 4'b0010,
    PWR_CHECK = 4'b0100,
    PWR_READY = 4'b1000
  } mfc_pwr_state_type;

endpackage

// >>> rtl/mfc_crc7.sv
// Serial seven-bit checksum over the identity body, one bit per clock
module mfc_crc7 import mfc_pkg::*; #(
  parameter int unsigned DATA_W = CID_BODY_W
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Control
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] data,
  // Result
  output logic      [6:0]        crc,
  output logic                   done
);

  localparam int unsigned IDX_W = $clog2(DATA_W);

  logic [6:0]       crc_q, crc_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic             busy_q, busy_d;
  logic             done_q, done_d;
  logic             fb;

  // Next state: shift most significant bit first
  always_comb begin
    crc_d  = crc_q;
    idx_d  = idx_q;
    busy_d = busy_q;
    done_d = done_q;
    fb     = data[idx_q] ^ crc_q[6];
    if (start) begin
      crc_d  = 7'h00;
      idx_d  = IDX_W'(DATA_W - 1);
      busy_d = 1'b1;
      done_d = 1'b0;
    end else if (busy_q) begin
      crc_d = {crc_q[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
      if (idx_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        idx_d = idx_q - 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_q  <= 7'h00;
      idx_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      crc_q  <= crc_d;
      idx_q  <= idx_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign crc  = crc_q;
  assign done = done_q;

endmodule

// >>> rtl/mfc_reg_bank.sv
// Card identification and capability register bank with an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite slave port were decided locally.
module mfc_reg_bank import mfc_pkg::*; #(
  parameter int unsigned POWERUP_CYCLES_P = POWERUP_CYCLES,
  parameter logic [7:0]  MAKER_CODE       = 8'h5A,          // Arbitrary value
  parameter logic [1:0]  DEVICE_KIND      = 2'h0,           // Arbitrary value
  parameter logic [7:0]  OEM_CODE         = 8'h22,          // Arbitrary value
  parameter logic [47:0] PRODUCT_LABEL    = 48'h54_45_53_54_30_31, // Arbitrary value
  parameter logic [7:0]  PRODUCT_REVISION = 8'h11,          // Arbitrary value
  parameter logic [7:0]  MAKE_DATE        = 8'h00,
  parameter logic [31:0] SERIAL_RESET     = 32'h0000_0001
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address channel
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  // Write data channel
  input  wire logic [AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  // Write response channel
  output logic      [1:0]            bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // Read address channel
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  // Read data channel
  output logic      [AXI_DATA_W-1:0] rdata,
  output logic      [1:0]            rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Register images for the command-line logic
  output logic      [31:0]           operating_conditions,
  output logic      [127:0]          card_identity,
  output logic      [127:0]          card_specific_data,
  output logic                       power_up_done
);

  localparam int unsigned CNT_W = $clog2(POWERUP_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(POWERUP_CYCLES_P - 1);

  // Write channel state
  logic                  aw_held_q, aw_held_d;
  logic [AXI_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic                  w_held_q, w_held_d;
  logic [AXI_DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0]            wstrb_q, wstrb_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  wr_commit;
  logic [7:0]            wr_ofs;
  logic                  restart_req;
  logic                  serial_wr;

  // Read channel state
  logic                  rvalid_q, rvalid_d;
  logic [AXI_DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0]            rresp_q, rresp_d;
  logic [7:0]            rd_ofs;

  // Power-up sequencer state
  mfc_pwr_state_type     st_q, st_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic                  crc_start;
  logic [6:0]            crc_val;
  logic                  crc_done;

  // Software-owned serial number and register images
  logic [31:0]           serial_q, serial_d;
  logic [31:0]           ocr_q, ocr_d;
  logic [127:0]          cid_q, cid_d;
  logic [127:0]          csd_q, csd_d;
  logic [CID_BODY_W-1:0] cid_body;

  // Identity body without checksum and stop bit
  // identity field packing
  assign cid_body = {MAKER_CODE, CID_RSVD, DEVICE_KIND, OEM_CODE, PRODUCT_LABEL,
                     PRODUCT_REVISION, serial_q, MAKE_DATE};

  // Checksum engine over the identity body
  mfc_crc7 #(
    .DATA_W (CID_BODY_W)
  ) u_crc7 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (crc_start),
    .data    (cid_body),
    .crc     (crc_val),
    .done    (crc_done)
  );

  // Handshake outputs
  assign awready = !aw_held_q && !bvalid_q;
  assign wready  = !w_held_q && !bvalid_q;
  assign arready = !rvalid_q;

  // Write commit once address and data are both held
  assign wr_commit   = aw_held_q && w_held_q && !bvalid_q;
  assign wr_ofs      = {awaddr_q[AXI_ADDR_W-1:2], 2'b00};
  assign restart_req = wr_commit && (wr_ofs == OFS_CONTROL) && wstrb_q[0]
                       && wdata_q[CTRL_RESTART_BIT];
  assign serial_wr   = wr_commit && (wr_ofs == OFS_SERIAL);

  // Write channel next state and decode
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    serial_d  = serial_q;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    if (wr_commit) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      case (wr_ofs)
        OFS_CONTROL: bresp_d = RESP_OKAY;
        OFS_SERIAL: begin
          bresp_d = RESP_OKAY;
          for (int i = 0; i < 4; i++) begin
            if (wstrb_q[i]) begin
              serial_d[8*i +: 8] = wdata_q[8*i +: 8];
            end
          end
        end
        OFS_OCR, OFS_STATUS,
        OFS_CID_W0, OFS_CID_W1, OFS_CID_W2, OFS_CID_W3,
        OFS_CSD_W0, OFS_CSD_W1, OFS_CSD_W2, OFS_CSD_W3: bresp_d = RESP_SLVERR;
        default: bresp_d = RESP_DECERR;
      endcase
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
      w_held_q  <= 1'b0;
      wdata_q   <= '0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      serial_q  <= SERIAL_RESET;
    end else begin
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
      w_held_q  <= w_held_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      serial_q  <= serial_d;
    end
  end

  // Read decode and data capture
  assign rd_ofs = {araddr[AXI_ADDR_W-1:2], 2'b00};

  // whole registers returned word by word
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      case (rd_ofs)
        OFS_OCR:     rdata_d = ocr_q;
        OFS_CID_W0:  rdata_d = cid_q[31:0];
        OFS_CID_W1:  rdata_d = cid_q[63:32];
        OFS_CID_W2:  rdata_d = cid_q[95:64];
        OFS_CID_W3:  rdata_d = cid_q[127:96];
        OFS_CSD_W0:  rdata_d = csd_q[31:0];
        OFS_CSD_W1:  rdata_d = csd_q[63:32];
        OFS_CSD_W2:  rdata_d = csd_q[95:64];
        OFS_CSD_W3:  rdata_d = csd_q[127:96];
        OFS_CONTROL: rdata_d = '0;
        OFS_STATUS: begin
          rdata_d[STAT_READY_BIT]               = (st_q == PWR_READY);
          rdata_d[STAT_CRC_OK_BIT]              = crc_done;
          rdata_d[STAT_STATE_LSB +: 4]          = st_q;
        end
        OFS_SERIAL:  rdata_d = serial_q;
        default:     rresp_d = RESP_DECERR;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // Power-up sequencer: wait, compute checksum, then report ready
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    crc_start = 1'b0;
    case (st_q)
      PWR_RESET: begin
        cnt_d = '0;
        st_d  = PWR_COUNT;
      end
      PWR_COUNT: begin
        if (cnt_q == CNT_LAST) begin
          st_d      = PWR_CHECK;
          crc_start = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      PWR_CHECK: begin
        if (crc_done) begin
          st_d = PWR_READY;
        end
      end
      PWR_READY: st_d = PWR_READY;
      default:   st_d = PWR_RESET;
    endcase
    // Software restart reruns the whole routine
    if (restart_req) begin
      st_d      = PWR_COUNT;
      cnt_d     = '0;
      crc_start = 1'b0;
    end else if (serial_wr && (st_q == PWR_CHECK || st_q == PWR_READY)) begin
      st_d      = PWR_CHECK;
      crc_start = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= PWR_RESET;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Register image next values
  always_comb begin
    // fixed access mode and voltage windows
    ocr_d = OCR_FIXED;
    // busy flag high only once ready
    ocr_d[OCR_BUSY_BIT] = (st_q == PWR_READY);
    cid_d = {cid_body, crc_val, CID_STOP_BIT};
    csd_d = CSD_VALUE;
  end

  // Register images
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ocr_q <= OCR_FIXED;
      cid_q <= '0;
      csd_q <= CSD_VALUE;
    end else begin
      ocr_q <= ocr_d;
      cid_q <= cid_d;
      csd_q <= csd_d;
    end
  end

  // Outputs
  assign bvalid               = bvalid_q;
  assign bresp                = bresp_q;
  assign rvalid               = rvalid_q;
  assign rdata                = rdata_q;
  assign rresp                = rresp_q;
  assign operating_conditions = ocr_q;
  assign card_identity        = cid_q;
  assign card_specific_data   = csd_q;
  assign power_up_done        = ocr_q[OCR_BUSY_BIT];

endmodule

// >>> testbench/mfc_reg_bank_properties.sv
// Port-level checks of the card register bank
module mfc_reg_bank_properties import mfc_pkg::*; #(
  parameter int unsigned POWERUP_CYCLES_P = 10
) (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Bus handshakes
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic [1:0]            bresp,
  input wire logic                  bvalid,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic                  rvalid,
  // Register images
  input wire logic [31:0]           operating_conditions,
  input wire logic [127:0]          card_identity,
  input wire logic [127:0]          card_specific_data,
  input wire logic                  power_up_done
);
  logic [15:0] low_cnt_q;
  logic [15:0] low_cnt_d;
  logic        ro_q;
  logic        ro_d;

  // Busy-low length and read-only target of the last write
  always_comb begin
    low_cnt_d = operating_conditions[31] ? 16'h0000 : low_cnt_q + {15'h0000, low_cnt_q != 16'hFFFF};
    ro_d = ro_q;
    if (awvalid && awready)
      ro_d = awaddr[7:2] == 6'h00 || (awaddr[7:2] >= 6'h04 && awaddr[7:2] <= 6'h0B)
             || awaddr[7:2] == 6'h0D;
  end
  always_ff @(posedge aclk) begin
    low_cnt_q <= aresetn ? low_cnt_d : 16'h0000;
    ro_q <= aresetn ? ro_d : 1'b0;
  end

  // Serial checksum, most significant bit first
  function automatic logic [6:0] mfc_crc7(input logic [119:0] b);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ b[i]) ? 7'h09 : 7'h00);
    return c;
  endfunction

  default clocking mfc_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  a_busy_reset_low: assert property ($rose(aresetn) |-> !operating_conditions[31])
    else $error("busy bit high after reset");
  a_busy_min_low: assert property ($rose(power_up_done) |-> low_cnt_q >= POWERUP_CYCLES_P)
    else $error("busy bit rose too early");
  a_ocr_fixed: assert property (operating_conditions[30:0] == 31'h40FF_8080)
    else $error("operating conditions field wrong");
  a_cid_checksum: assert property ($rose(power_up_done) |->
    card_identity[7:0] == {mfc_crc7(card_identity[127:8]), 1'b1}) else $error("identity checksum");
  a_csd_blocks: assert property (card_specific_data[83:77] == 7'h48
    && card_specific_data[25:21] == 5'h12) else $error("block length fields wrong");
  a_csd_timing: assert property ({card_specific_data[119:112], card_specific_data[103:96]}
    == 16'h4F32) else $error("timing fields wrong");
  a_csd_groups: assert property (card_specific_data[73:37] == '1
    && card_specific_data[36:31] == 6'h1F) else $error("group or size fields wrong");
  a_write_refused: assert property (s_wr_taken ##1 ro_q |=> bvalid && bresp == RESP_SLVERR)
    else $error("write to read-only register not refused");
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read answer late");
endmodule

bind mfc_reg_bank mfc_reg_bank_properties #(.POWERUP_CYCLES_P(POWERUP_CYCLES_P))
  u_mfc_reg_bank_properties (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .operating_conditions(operating_conditions), .card_identity(card_identity),
  .card_specific_data(card_specific_data), .power_up_done(power_up_done));

// >>> testbench/mfc_host_model.sv
// Bus master standing in for the host that reads the card registers
module mfc_host_model import mfc_pkg::*; (
  // Clock
  input  wire logic                  aclk,
  // Write side
  output logic      [AXI_ADDR_W-1:0] awaddr,
  output logic      [2:0]            awprot,
  output logic                       awvalid,
  input  wire logic                  awready,
  output logic      [AXI_DATA_W-1:0] wdata,
  output logic      [3:0]            wstrb,
  output logic                       wvalid,
  input  wire logic                  wready,
  input  wire logic                  bvalid,
  output logic                       bready,
  // Read side
  output logic      [AXI_ADDR_W-1:0] araddr,
  output logic      [2:0]            arprot,
  output logic                       arvalid,
  input  wire logic                  arready,
  input  wire logic                  rvalid,
  output logic                       rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic fin;
    fin = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    awprot <= 3'($urandom());
    {awvalid, wvalid, bready} <= 3'h7;
    while (!fin) begin
      @(posedge aclk);
      if (awvalid && awready)
        {awvalid, awaddr} <= {1'b0, ~a};  // Released address shows garbage
      if (wvalid && wready)
        {wvalid, wdata} <= {1'b0, ~d};
      fin = bvalid;
      if (fin)
        bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic fin;
    fin = 1'b0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    arprot <= 3'($urandom());
    while (!fin) begin
      @(posedge aclk);
      if (arvalid && arready)
        {arvalid, araddr} <= {1'b0, ~a};
      fin = rvalid;
      if (fin)
        rready <= 1'b0;
    end
  endtask
endmodule

// >>> testbench/mfc_reg_bank_tb.sv
// Self-checking bench of the card register bank
module mfc_reg_bank_tb import mfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned  PU    = 10;
  localparam logic [31:0]  SER0  = 32'h1357_9BDF;
  localparam logic [31:0]  BUSY  = 32'h40FF_8080;
  localparam logic [31:0]  DONE  = 32'hC0FF_8080;
  localparam logic [127:0] CID_M = ~128'hFE;
  localparam logic [127:0] CSD_E = {8'h0, 8'h4F, 8'h0, 8'h32, 12'h0, 4'h9, 6'h0, {37{1'b1}},
                                    6'h1F, 5'h0, 4'h9, 21'h0, 1'b1};
  localparam logic [127:0] CSD_M = {8'h0, 8'hFF, 8'h0, 8'hFF, 12'h0, 10'h3F8, {37{1'b1}},
                                    6'h3F, 5'h0, 5'h1F, 20'h0, 1'b1};
  localparam logic [7:0]   RO_A [10] = '{OFS_OCR, OFS_CID_W0, OFS_CID_W1, OFS_CID_W2,
    OFS_CID_W3, OFS_CSD_W0, OFS_CSD_W1, OFS_CSD_W2, OFS_CSD_W3, OFS_STATUS};
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} mfc_exp_type;

  logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, power_up_done;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [2:0]            awprot, arprot;
  logic [AXI_DATA_W-1:0] wdata, rdata;
  logic [3:0]            wstrb, stb;
  logic [1:0]            bresp, rresp;
  logic [31:0]           operating_conditions, ser;
  logic [127:0]          card_identity, card_specific_data;
  mfc_exp_type           rq [$];
  logic [1:0]            bq [$];
  int                    fails = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  mfc_reg_bank #(.POWERUP_CYCLES_P(PU), .MAKER_CODE(8'hA7), .DEVICE_KIND(2'h2),
    .OEM_CODE(8'h3C), .PRODUCT_LABEL(48'h4D4F_4445_4C31), .PRODUCT_REVISION(8'h12),
    .MAKE_DATE(8'h45), .SERIAL_RESET(SER0)) u_mfc_reg_bank (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .operating_conditions(operating_conditions), .card_identity(card_identity),
    .card_specific_data(card_specific_data), .power_up_done(power_up_done));
  mfc_host_model u_mfc_host_model (.aclk(aclk), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  function automatic logic [127:0] cid_of(input logic [31:0] s);
    return {8'hA7, 6'h0, 2'h2, 8'h3C, 48'h4D4F_4445_4C31, 8'h12, s, 8'h45, 7'h0, 1'b1};
  endfunction

  task chk_rd(input mfc_exp_type x);
    cmp_count++;
    if ((rdata & x.m) !== (x.d & x.m) || rresp !== x.r) begin
      fails++;
      $display("[ERR] %0t read %h/%h want %h/%h", $time, rdata, rresp, x.d, x.r);
    end
  endtask

  task chk_b(input logic [1:0] r);
    cmp_count++;
    if (bresp !== r) begin
      fails++;
      $display("[ERR] %0t write resp %h want %h", $time, bresp, r);
    end
  endtask

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
    rq.push_back('{d, m, r});
    u_mfc_host_model.rd(a);
  endtask

  task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
              input logic [1:0] r);
    bq.push_back(r);
    u_mfc_host_model.wr(a, d, s);
  endtask

  task rd128(input logic [7:0] a, input logic [127:0] d, m);
    for (int i = 0; i < 4; i++)
      rd_chk(a + 8'(4 * i), d[32*i +: 32], m[32*i +: 32], RESP_OKAY);
  endtask

  task rd_all(input logic [31:0] s);
    rd_chk(OFS_OCR, DONE, '1, RESP_OKAY);
    rd128(OFS_CID_W0, cid_of(s), CID_M);
    rd128(OFS_CSD_W0, CSD_E, CSD_M);
  endtask

  task wait_ready;
    while (power_up_done !== 1'b1)
      @(posedge aclk);
  endtask

  // Response watcher takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready)
      chk_rd(rq.pop_front());
    if (bvalid && bready)
      chk_b(bq.pop_front());
  end

  // Cuts a hung run short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    aresetn = 1'b0;
    void'($urandom(32'h3bc8799b));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFS_OCR, BUSY, '1, RESP_OKAY);
    wait_ready();
    rd_all(SER0);
    foreach (RO_A[i])
      wr_chk(RO_A[i], $urandom(), 4'($urandom()), RESP_SLVERR);
    rd_chk(8'h04, 32'h0, '1, RESP_DECERR);
    wr_chk(8'hFC, $urandom(), 4'hF, RESP_DECERR);
    rd_all(SER0);
    ser = $urandom();
    stb = 4'($urandom());
    wr_chk(OFS_SERIAL, ser, stb, RESP_OKAY);
    // Bytes without strobe keep the reset serial
    for (int i = 0; i < 4; i++)
      if (!stb[i])
        ser[8*i +: 8] = SER0[8*i +: 8];
    rd_chk(OFS_OCR, BUSY, '1, RESP_OKAY);
    wait_ready();
    rd_chk(OFS_SERIAL, ser, '1, RESP_OKAY);
    rd_all(ser);
    wr_chk(OFS_CONTROL, 32'h1, 4'h1, RESP_OKAY);
    rd_chk(OFS_OCR, BUSY, '1, RESP_OKAY);
    wait_ready();
    rd_chk(OFS_OCR, DONE, '1, RESP_OKAY);
    @(posedge aclk);
    print_verdict();
  end
endmodule
